// >>> shared/ora_defines.svh
`ifndef ORA_DEFINES_SVH
`define ORA_DEFINES_SVH

`define ORA_NUM_ROUTES      3
`define ORA_LANES           6
`define ORA_LANE_W          3
`define ORA_SAMPLE_W        16
`define ORA_CTRL_W          16
`define ORA_FRAC_BITS       14
`define ORA_PHASE_LUT_BITS  6
`define ORA_OVF_W           32
`define ORA_LAT_NS          26
`define ORA_SAMPLE_PS       500
`define ORA_LAT_SAMPLES     ((`ORA_LAT_NS * 1000) / `ORA_SAMPLE_PS)
`define ORA_CORE_STAGES     3
`define ORA_BUF_DEPTH       2

`endif

// >>> shared/ora_pkg.sv
`include "ora_defines.svh"
package ora_pkg;
  typedef logic signed [`ORA_SAMPLE_W-1:0] ora_sample_t;
  typedef logic [`ORA_LANE_W-1:0]          ora_lane_t;
  typedef logic [`ORA_CTRL_W-1:0]          ora_ctrl_t;
  typedef struct packed {
    logic        v;
    logic [1:0]  mk;
    ora_sample_t i;
    ora_sample_t q;
  } ora_word_t;
endpackage : ora_pkg

// >>> verilog/ora_trig_rom.sv
`timescale 1ns/1ps
`include "ora_defines.svh"
module ora_trig_rom (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire ora_pkg::ora_ctrl_t phase_i,
  output ora_pkg::ora_sample_t    cos_o,
  output ora_pkg::ora_sample_t    sin_o
);
  import ora_pkg::*;
  localparam int LB = `ORA_PHASE_LUT_BITS;

  ora_sample_t cos_next;
  ora_sample_t sin_next;
  logic [LB-1:0] p;

  // Quarter wave of sine, Q1.14, 17 points
  function automatic ora_sample_t quarter(input logic [LB-2:0] k);
    case (k)
      5'h00: quarter = 16'sh0000;
      5'h01: quarter = 16'sh0646;
      5'h02: quarter = 16'sh0C7C;
      5'h03: quarter = 16'sh1294;
      5'h04: quarter = 16'sh187E;
      5'h05: quarter = 16'sh1E2B;
      5'h06: quarter = 16'sh238E;
      5'h07: quarter = 16'sh289A;
      5'h08: quarter = 16'sh2D41;
      5'h09: quarter = 16'sh3179;
      5'h0A: quarter = 16'sh3537;
      5'h0B: quarter = 16'sh3871;
      5'h0C: quarter = 16'sh3B21;
      5'h0D: quarter = 16'sh3D3F;
      5'h0E: quarter = 16'sh3EC5;
      5'h0F: quarter = 16'sh3FB1;
      5'h10: quarter = 16'sh4000;
      default: quarter = 16'sh0000;
    endcase
  endfunction : quarter

  function automatic ora_sample_t sine(input logic [LB-1:0] a);
    logic [LB-2:0] k;
    k = a[LB-2] ? (5'h10 - {1'b0, a[LB-3:0]}) : {1'b0, a[LB-3:0]};
    sine = a[LB-1] ? -quarter(k) : quarter(k);
  endfunction : sine

  always_comb
  begin
    p        = phase_i[`ORA_CTRL_W-1 -: LB];
    sin_next = sine(p);
    cos_next = sine(6'(p + 6'h10));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cos_o <= 16'sh0000;
      sin_o <= 16'sh0000;
    end
    else
    begin
      cos_o <= cos_next;
      sin_o <= sin_next;
    end
  end
endmodule : ora_trig_rom

// >>> verilog/ora_skid_buffer.sv
`timescale 1ns/1ps
`include "ora_defines.svh"
module ora_skid_buffer #(
  parameter int W = 34
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  import ora_pkg::*;

  if (W < 1)
  begin : g_bad_width
    $error("ora_skid_buffer: W must be positive");
  end

  logic [1:0]   cnt_reg;
  logic [1:0]   cnt_next;
  logic [W-1:0] d1_reg;
  logic [W-1:0] d1_next;
  logic [W-1:0] d0_next;
  logic         push;
  logic         pop;

  always_comb
  begin
    push     = in_valid_i && in_ready_o;
    pop      = out_valid_o && out_ready_i;
    d0_next  = out_data_o;
    d1_next  = d1_reg;
    cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    case ({push, pop})
      2'b10:
      begin
        if (cnt_reg == 2'h0)
          d0_next = in_data_i;
        else
          d1_next = in_data_i;
      end
      2'b01: d0_next = d1_reg;
      2'b11:
      begin
        if (cnt_reg == 2'h1)
          d0_next = in_data_i;
        else
        begin
          d0_next = d1_reg;
          d1_next = in_data_i;
        end
      end
      default: ;
    endcase
  end

  // Ready is registered so a stall never reaches the source combinationally
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg     <= 2'h0;
      d1_reg      <= '0;
      out_data_o  <= '0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b0;
    end
    else
    begin
      cnt_reg     <= cnt_next;
      d1_reg      <= d1_next;
      out_data_o  <= d0_next;
      out_valid_o <= (cnt_next != 2'h0);
      in_ready_o  <= (cnt_next != 2'(`ORA_BUF_DEPTH));
    end
  end
endmodule : ora_skid_buffer

// >>> verilog/ora_output_route_adder.sv
`timescale 1ns/1ps
`include "ora_defines.svh"
// Notes on behaviour
// - Each output lane offers three routes adding another lane's signal.
// - Every route has enable, source, amplitude and phase settings.
// - Router enable 1 turns the whole route-and-add stage on, 0 off.
// - Route enable 1 adds that route into the sum, 0 leaves it out.
// - Route source picks which lane's modulated signal feeds the route.
// - A route refuses its own lane index as source.
// - Routed signal is scaled by its route amplitude before adding.
// - Routed signal is rotated by its route phase, top 6 bits only (64 steps), before adding.
// - Output is default signal plus all enabled scaled, rotated routes.
// - One source may feed many destinations, each with own settings.
// - All routing and arithmetic works on digital samples ahead of the DAC.
// - Only waveform samples are routed; markers stay with their own lane.
// - A readable counter counts samples whose sum exceeds DAC range.
// - An overflowing sum is clamped to full scale instead of wrapping.
// - Route adds A(I cos - Q sin) to I and A(I sin + Q cos) to Q.
// - Enabling the router adds 26 ns, 52 samples, of latency.
module ora_output_route_adder #(
  parameter int NUM_LANES  = `ORA_LANES,
  parameter int LANE_INDEX = 0
) (
  input  wire logic                                  CORE_CLK_I,
  input  wire logic                                  RESET_I,
  input  wire logic                                  ROUTER_EN_I,
  input  wire logic [`ORA_NUM_ROUTES-1:0]            ROUTE_EN_I,
  input  wire ora_pkg::ora_lane_t [`ORA_NUM_ROUTES-1:0] ROUTE_SRC_I,
  input  wire ora_pkg::ora_ctrl_t [`ORA_NUM_ROUTES-1:0] ROUTE_AMP_I,
  input  wire ora_pkg::ora_ctrl_t [`ORA_NUM_ROUTES-1:0] ROUTE_PHASE_I,
  input  wire logic                                  S_VALID_I,
  output logic                                       S_READY_O,
  input  wire ora_pkg::ora_sample_t                  LANE_I_I,
  input  wire ora_pkg::ora_sample_t                  LANE_Q_I,
  input  wire logic [1:0]                            LANE_MARKER_I,
  input  wire ora_pkg::ora_sample_t [NUM_LANES-1:0]  SRC_I_I,
  input  wire ora_pkg::ora_sample_t [NUM_LANES-1:0]  SRC_Q_I,
  input  wire logic                                  OVF_CLEAR_I,
  output logic                                       M_VALID_O,
  input  wire logic                                  M_READY_I,
  output ora_pkg::ora_sample_t                       OUT_I_O,
  output ora_pkg::ora_sample_t                       OUT_Q_O,
  output logic [1:0]                                 OUT_MARKER_O,
  output logic [`ORA_NUM_ROUTES-1:0]                 ROUTE_REFUSED_O,
  output logic [`ORA_OVF_W-1:0]                      OVF_COUNT_O
);
  import ora_pkg::*;

  localparam int NR  = `ORA_NUM_ROUTES;
  localparam int FB  = `ORA_FRAC_BITS;
  localparam int PAD = `ORA_LAT_SAMPLES - `ORA_CORE_STAGES;
  localparam int BW  = $bits(ora_word_t) - 1;
  localparam logic signed [21:0] SMAX = 22'sh007FFF;
  localparam logic signed [21:0] SMIN = 22'sh3F8000;
  localparam logic [`ORA_OVF_W-1:0] CMAX = '1;

  if (NUM_LANES < 2 || NUM_LANES > (1 << `ORA_LANE_W) || LANE_INDEX < 0 ||
      LANE_INDEX >= NUM_LANES || PAD < 2)
  begin : g_bad_params
    $error("ora_output_route_adder: unsupported lane count, lane index or latency");
  end

  ora_word_t                  w0_reg, w0_next;
  ora_word_t                  w1_reg, w1_next;
  ora_word_t                  w2_reg, w2_next;
  ora_word_t                  w3_reg, w3_next;
  ora_word_t [PAD-1:0]        pad_reg, pad_next;
  ora_sample_t [NR-1:0]       si0_reg, si0_next;
  ora_sample_t [NR-1:0]       sq0_reg, sq0_next;
  ora_ctrl_t [NR-1:0]         amp0_reg, amp0_next;
  ora_ctrl_t [NR-1:0]         amp1_reg, amp1_next;
  logic [NR-1:0]              act0_reg, act0_next;
  logic [NR-1:0][17:0]        ri1_reg, ri1_next;
  logic [NR-1:0][17:0]        rq1_reg, rq1_next;
  logic [NR-1:0][19:0]        ci2_reg, ci2_next;
  logic [NR-1:0][19:0]        cq2_reg, cq2_next;
  ora_sample_t [NR-1:0]       cos_w;
  ora_sample_t [NR-1:0]       sin_w;
  logic [NR-1:0]              ok_w;
  logic [NR-1:0]              refused_next;
  logic [`ORA_OVF_W-1:0]      cnt_next;
  logic signed [21:0]         sum_i;
  logic signed [21:0]         sum_q;
  logic                       ovf_w;
  logic                       adv;
  ora_word_t                  tail;
  logic                       buf_push;

  // a*c - b*d, rescaled from Q1.14 coefficients
  function automatic logic [17:0] rot(input ora_sample_t a, input ora_sample_t b,
                                      input ora_sample_t c, input ora_sample_t d);
    logic signed [31:0] t1;
    logic signed [31:0] t2;
    logic signed [32:0] t;
    t1  = a * c;
    t2  = b * d;
    t   = 33'(t1) - 33'(t2);
    rot = 18'(t >>> FB);
  endfunction : rot

  function automatic logic [19:0] scale(input logic signed [17:0] x, input logic signed [15:0] g);
    logic signed [33:0] t;
    t     = x * g;
    scale = 20'(t >>> FB);
  endfunction : scale

  function automatic ora_sample_t sat(input logic signed [21:0] s);
    if (s > SMAX)
      sat = 16'sh7FFF;
    else if (s < SMIN)
      sat = 16'sh8000;
    else
      sat = 16'(s);
  endfunction : sat

  // One lookup per route so each routed instance keeps its own phase
  for (genvar r = 0; r < NR; r++)
  begin : g_route
    ora_trig_rom u_rom (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RESET_I),
      .phase_i (ROUTE_PHASE_I[r]),
      .cos_o   (cos_w[r]),
      .sin_o   (sin_w[r])
    );
    assign ok_w[r] = (ROUTE_SRC_I[r] != ora_lane_t'(LANE_INDEX)) &&
                     (int'(ROUTE_SRC_I[r]) < NUM_LANES);
  end

  always_comb
  begin
    sum_i = 22'($signed(w2_reg.i));
    sum_q = 22'($signed(w2_reg.q));
    for (int r = 0; r < NR; r++)
    begin
      sum_i = sum_i + 22'($signed(ci2_reg[r]));
      sum_q = sum_q + 22'($signed(cq2_reg[r]));
    end
    ovf_w = (sum_i > SMAX) || (sum_i < SMIN) || (sum_q > SMAX) || (sum_q < SMIN);
  end

  // Whole datapath holds while the output buffer is full
  always_comb
  begin
    w0_next   = w0_reg;
    w1_next   = w1_reg;
    w2_next   = w2_reg;
    w3_next   = w3_reg;
    pad_next  = pad_reg;
    si0_next  = si0_reg;
    sq0_next  = sq0_reg;
    amp0_next = amp0_reg;
    amp1_next = amp1_reg;
    act0_next = act0_reg;
    ri1_next  = ri1_reg;
    rq1_next  = rq1_reg;
    ci2_next  = ci2_reg;
    cq2_next  = cq2_reg;
    if (adv)
    begin
      // Marker bits only ever follow their own lane
      w0_next = '{v: S_VALID_I, mk: LANE_MARKER_I, i: LANE_I_I, q: LANE_Q_I};
      w1_next = w0_reg;
      w2_next = w1_reg;
      w3_next = '{v: w2_reg.v, mk: w2_reg.mk, i: sat(sum_i), q: sat(sum_q)};
      pad_next = {pad_reg[PAD-2:0], w3_reg};
      for (int r = 0; r < NR; r++)
      begin
        act0_next[r] = ROUTER_EN_I && ROUTE_EN_I[r] && ok_w[r];
        si0_next[r]  = ok_w[r] ? SRC_I_I[ROUTE_SRC_I[r]] : 16'sh0000;
        sq0_next[r]  = ok_w[r] ? SRC_Q_I[ROUTE_SRC_I[r]] : 16'sh0000;
        amp0_next[r] = ROUTE_AMP_I[r];
        amp1_next[r] = amp0_reg[r];
        if (act0_reg[r])
        begin
          ri1_next[r] = rot(si0_reg[r], sq0_reg[r], cos_w[r], sin_w[r]);
          rq1_next[r] = rot(si0_reg[r], sq0_reg[r], sin_w[r], -cos_w[r]);
        end
        else
        begin
          ri1_next[r] = 18'h00000;
          rq1_next[r] = 18'h00000;
        end
        ci2_next[r] = scale(ri1_reg[r], amp1_reg[r]);
        cq2_next[r] = scale(rq1_reg[r], amp1_reg[r]);
      end
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      w0_reg   <= '0;
      w1_reg   <= '0;
      w2_reg   <= '0;
      w3_reg   <= '0;
      pad_reg  <= '0;
      si0_reg  <= '0;
      sq0_reg  <= '0;
      amp0_reg <= '0;
      amp1_reg <= '0;
      act0_reg <= '0;
      ri1_reg  <= '0;
      rq1_reg  <= '0;
      ci2_reg  <= '0;
      cq2_reg  <= '0;
    end
    else
    begin
      w0_reg   <= w0_next;
      w1_reg   <= w1_next;
      w2_reg   <= w2_next;
      w3_reg   <= w3_next;
      pad_reg  <= pad_next;
      si0_reg  <= si0_next;
      sq0_reg  <= sq0_next;
      amp0_reg <= amp0_next;
      amp1_reg <= amp1_next;
      act0_reg <= act0_next;
      ri1_reg  <= ri1_next;
      rq1_reg  <= rq1_next;
      ci2_reg  <= ci2_next;
      cq2_reg  <= cq2_next;
    end
  end

  // Counter: an overflow in the clearing cycle still counts
  always_comb
  begin
    cnt_next     = OVF_COUNT_O;
    refused_next = ROUTE_EN_I & ~ok_w;
    if (OVF_CLEAR_I)
      cnt_next = '0;
    if (adv && w2_reg.v && ovf_w && (cnt_next != CMAX))
      cnt_next = cnt_next + 1'b1;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      OVF_COUNT_O     <= '0;
      ROUTE_REFUSED_O <= '0;
    end
    else
    begin
      OVF_COUNT_O     <= cnt_next;
      ROUTE_REFUSED_O <= refused_next;
    end
  end

  // Toggling the router mid-stream drops or repeats the words in flight
  assign tail     = ROUTER_EN_I ? pad_reg[PAD-1] : w0_reg;
  assign buf_push = tail.v && adv;

  ora_skid_buffer #(
    .W (BW)
  ) u_out_buf (
    .clk_i       (CORE_CLK_I),
    .rst_i       (RESET_I),
    .in_valid_i  (tail.v),
    .in_ready_o  (adv),
    .in_data_i   ({tail.mk, tail.i, tail.q}),
    .out_valid_o (M_VALID_O),
    .out_ready_i (M_READY_I),
    .out_data_o  ({OUT_MARKER_O, OUT_I_O, OUT_Q_O})
  );
  assign S_READY_O = adv;

  // Checking helpers
  logic [7:0] run_cnt;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I || !adv || !ROUTER_EN_I)
      run_cnt <= 8'h00;
    else if (run_cnt != 8'hFF)
      run_cnt <= run_cnt + 8'h01;
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_bypass_take;
    S_VALID_I && adv && !ROUTER_EN_I ##1 !ROUTER_EN_I;
  endsequence
  sequence s_ovf_sample;
    adv && w2_reg.v && ovf_w && !OVF_CLEAR_I && OVF_COUNT_O != CMAX;
  endsequence

  AST_SELF_REFUSED: assert property (ROUTE_EN_I[0] && ROUTE_SRC_I[0] == ora_lane_t'(LANE_INDEX) |=>
    ROUTE_REFUSED_O[0] && (!$past(adv) || !act0_reg[0]))
    else $error("own lane accepted as route source");
  AST_ROUTER_OFF: assert property (adv && !ROUTER_EN_I |=> act0_reg == '0)
    else $error("route active while router disabled");
  AST_ROUTE_OFF_ZERO: assert property (adv && !act0_reg[0] |=> ri1_reg[0] == '0 && rq1_reg[0] == '0)
    else $error("disabled route still contributes");
  AST_SRC_SELECT: assert property (adv && ok_w[0] |=> si0_reg[0] == $past(SRC_I_I[ROUTE_SRC_I[0]]))
    else $error("route took wrong source lane");
  AST_CLAMP_HIGH: assert property (adv && w2_reg.v && sum_i > SMAX |=> w3_reg.i == 16'sh7FFF)
    else $error("positive overflow not clamped");
  AST_OVF_STEP: assert property (s_ovf_sample |=> OVF_COUNT_O == $past(OVF_COUNT_O) + 1'b1)
    else $error("overflow counter did not step");
  AST_OVF_HOLD: assert property (OVF_COUNT_O == CMAX && !OVF_CLEAR_I |=> OVF_COUNT_O == CMAX)
    else $error("overflow counter rolled over");
  AST_BYPASS: assert property (s_bypass_take |-> tail.v && tail.i == $past(LANE_I_I))
    else $error("bypass path added latency");
  AST_LATENCY: assert property (run_cnt >= 8'(PAD) |-> pad_reg[PAD-1] == $past(w3_reg, PAD))
    else $error("router latency differs from 52 samples");
endmodule : ora_output_route_adder

// >>> tb/ora_lane_model.sv
`timescale 1ns/1ps
module ora_lane_model #(
  parameter int LANES = 6
) (
  input  wire logic                           clk_i,
  input  wire logic                           stall_i,
  input  wire logic                           slow_i,
  output logic                                ready_o,
  output ora_pkg::ora_sample_t [LANES-1:0]    src_i_o,
  output ora_pkg::ora_sample_t [LANES-1:0]    src_q_o
);
  import ora_pkg::*;

  initial ready_o = 1'b0;

  // Slow mode toggles ready so every word must stand until taken
  always @(negedge clk_i)
    ready_o <= stall_i ? 1'b0 : (slow_i ? ~ready_o : 1'b1);

  // Distinct level per lane, so a wrong source select shows in the sum
  always_comb
    for (int k = 0; k < LANES; k++)
    begin
      src_i_o[k] = 16'(4096 * (k + 1));
      src_q_o[k] = 16'(-2048 * (k + 1));
    end
endmodule : ora_lane_model

// >>> tb/ora_output_route_adder_tb.sv
`timescale 1ns/1ps
`include "ora_defines.svh"
module ora_output_route_adder_tb;
  import ora_pkg::*;
  localparam int LANES = `ORA_LANES;
  logic                    clk = 1'b0, rst = 1'b1, router_en = 1'b0, s_valid = 1'b0, ovf_clear = 1'b0;
  logic                    stall = 1'b0, slow = 1'b0, m_ready, s_ready, m_valid, seen_full;
  logic [2:0]              ren = 3'h0, refused;
  ora_lane_t [2:0]         rsrc = '0;
  ora_ctrl_t [2:0]         ramp = '0, rph = '0;
  ora_sample_t             lane_i = 16'h0, lane_q = 16'h0, out_i, out_q;
  ora_sample_t [LANES-1:0] src_i, src_q;
  logic [1:0]              lane_mk = 2'h0, out_mk;
  logic [`ORA_OVF_W-1:0]   ovf;
  logic [31:0]             got[$];
  int                      errors = 0, total_checks = 0;

  initial forever #20 clk = ~clk;

  ora_output_route_adder #(.NUM_LANES(LANES), .LANE_INDEX(0)) ora_output_route_adder_i (
    .CORE_CLK_I(clk), .RESET_I(rst), .ROUTER_EN_I(router_en), .ROUTE_EN_I(ren), .ROUTE_SRC_I(rsrc),
    .ROUTE_AMP_I(ramp), .ROUTE_PHASE_I(rph), .S_VALID_I(s_valid), .S_READY_O(s_ready),
    .LANE_I_I(lane_i), .LANE_Q_I(lane_q), .LANE_MARKER_I(lane_mk), .SRC_I_I(src_i), .SRC_Q_I(src_q),
    .OVF_CLEAR_I(ovf_clear), .M_VALID_O(m_valid), .M_READY_I(m_ready), .OUT_I_O(out_i), .OUT_Q_O(out_q),
    .OUT_MARKER_O(out_mk), .ROUTE_REFUSED_O(refused), .OVF_COUNT_O(ovf));

  ora_lane_model #(.LANES(LANES)) ora_lane_model_i (
    .clk_i(clk), .stall_i(stall), .slow_i(slow), .ready_o(m_ready), .src_i_o(src_i), .src_q_o(src_q));

  always @(posedge clk)
    if (m_valid === 1'b1 && m_ready === 1'b1)
      got.push_back({out_i, out_q});

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic signed [31:0] seen, input int exp, input int tol);
    int d;
    d = seen - exp;
    total_checks++;
    if ((seen ^ seen) !== 32'h0 || d > tol || d < -tol)
    begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : chk

  task fail_wait(input string nm);
    errors++;
    $display("mismatch %s expected handshake seen none", nm);
    finish_test();
  endtask : fail_wait

  // Controller side encodes amplitude and phase settings as 16-bit words
  task cfg(input int r, input bit e, input int s, input real a, input real deg);
    @(negedge clk);
    ren[r] = e;
    rsrc[r] = s[2:0];
    ramp[r] = 16'($rtoi(a * 16384.0));
    rph[r] = 16'($rtoi(deg / 360.0 * 65536.0));
  endtask : cfg

  function automatic int model(input bit want_q, input int li, input int lq);
    real acc, a, p, si, sq;
    acc = want_q ? lq : li;
    for (int r = 0; r < 3; r++)
      if (router_en && ren[r] && rsrc[r] != 3'h0 && rsrc[r] < LANES)
      begin
        a = $signed(ramp[r]) / 16384.0;
        p = rph[r] * 6.283185307179586 / 65536.0;
        si = src_i[rsrc[r]];
        sq = src_q[rsrc[r]];
        acc += want_q ? a * (si * $sin(p) + sq * $cos(p)) : a * (si * $cos(p) - sq * $sin(p));
      end
    if (acc > 32767.0)
      return 32767;
    if (acc < -32768.0)
      return -32768;
    return int'(acc);
  endfunction : model

  task go(input string nm, input int li, input int lq, input logic [1:0] mk, input int tol);
    int n, ei, eq, lat;
    repeat (3) @(negedge clk);
    ei = model(1'b0, li, lq);
    eq = model(1'b1, li, lq);
    lat = router_en ? `ORA_LAT_SAMPLES + 2 : 2;
    lane_i = li[15:0];
    lane_q = lq[15:0];
    lane_mk = mk;
    s_valid = 1'b1;
    n = 0;
    while (s_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
      fail_wait(nm);
    @(negedge clk);
    s_valid = 1'b0;
    n = 1;
    while (m_valid !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk({nm, " latency"}, n, lat, 0);
    chk({nm, " out i"}, out_i, ei, tol);
    chk({nm, " out q"}, out_q, eq, tol);
    chk({nm, " marker"}, out_mk, mk, 0);
    $display("test %s done", nm);
  endtask : go

  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cfg(0, 1, 1, 1.0, 0.0);
    go("router off", 1234, -4321, 2'h1, 0);
    // Let the bypass word leave the pad stages before the path mux switches
    repeat (60) @(negedge clk);
    router_en = 1'b1;
    go("single route", 1000, 2000, 2'h2, 4);
    cfg(0, 1, 2, 0.5, 90.0);
    cfg(1, 1, 3, -0.25, 180.0);
    cfg(2, 1, 4, 0.25, 45.0);
    slow = 1'b1;
    go("three routes", 1000, -500, 2'h3, 6);
    cfg(1, 0, 3, -0.25, 180.0);
    go("route disabled", -700, 300, 2'h0, 6);
    cfg(0, 1, 1, 0.25, 0.0);
    cfg(2, 1, 1, 0.5, 180.0);
    go("shared source", 50, -60, 2'h1, 6);
    cfg(0, 1, 0, 1.0, 0.0);
    cfg(1, 1, 6, 1.0, 0.0);
    cfg(2, 0, 1, 1.0, 0.0);
    go("own source", 777, -888, 2'h2, 2);
    chk("refused routes", refused, 3, 0);
    cfg(0, 1, 1, 1.0, 0.0);
    cfg(1, 0, 2, 1.0, 0.0);
    ovf_clear = 1'b1;
    @(negedge clk);
    ovf_clear = 1'b0;
    chk("count cleared", ovf, 0, 0);
    go("overflow high", 32000, 1000, 2'h1, 2);
    chk("count one", ovf, 1, 0);
    go("overflow low", -32000, -32000, 2'h2, 2);
    chk("count two", ovf, 2, 0);
    // Burst against a stalled sink: the buffer must refuse, then drain in order
    @(negedge clk);
    router_en = 1'b0;
    slow = 1'b0;
    // Last slow-mode word must be taken before the burst record starts
    repeat (4) @(negedge clk);
    got.delete();
    seen_full = 1'b0;
    fork
      begin
        stall = 1'b1;
        repeat (30) @(negedge clk);
        stall = 1'b0;
      end
      begin
        for (int k = 0; k < 5; k++)
        begin
          lane_i = 16'(300 * k + 50);
          lane_q = 16'(-(200 * k + 7));
          s_valid = 1'b1;
          for (int n = 0; s_ready !== 1'b1; n++)
          begin
            seen_full = 1'b1;
            if (n >= 200)
              fail_wait("burst");
            @(negedge clk);
          end
          @(negedge clk);
        end
        s_valid = 1'b0;
      end
    join
    for (int n = 0; got.size() < 5; n++)
    begin
      if (n >= 100)
        fail_wait("burst drain");
      @(negedge clk);
    end
    chk("burst refused", seen_full, 1, 0);
    for (int k = 0; k < 5; k++)
    begin
      chk("burst i", $signed(got[k][31:16]), 300 * k + 50, 0);
      chk("burst q", $signed(got[k][15:0]), -(200 * k + 7), 0);
    end
    $display("test burst done");
    finish_test();
  end
endmodule : ora_output_route_adder_tb
